// ==== design/crg_cfg.svh ====
// crg_cfg.svh: offsets, field positions and reset values for the clock/reset control block
//----------------------------------------
// Summary of operation
//----------------------------------------
// Summary of operation
// - slow clock divided by slow_clock_divider plus one; divider resets to 0xf.
// - slow_osc_status reads high while slow clock is selected; resets low.
// - soft_start_dwell code n holds each step 2^(n+1) cycles; resets to 4.
// - slow-to-fast switch starts divider at maximum, lowers by one per dwell.
// - fast clock divided by fast_clock_divider plus one; resets to zero.
// - system_clock_select picks slow (0) or fast (1); set after power-on reset.
// - fast_osc_status high when fast oscillator enabled or fast clock selected.
// - fast_osc_enable starts oscillator; cleared on deep sleep/hibernate; set at power-on.
// - chip_soft_reset_request resets low-voltage domain and LIN slave; self-clears.
// - chip_hard_reset_request triggers hard reset of whole chip.
// - cause flags: power-on bit 0, over voltage 1, under voltage 3, watchdog 5, temp 6.
// - writing one to clear bits 8, 9, 11, 13, 14 clears matching cause flag.
// - module clock stop bit one forces that module clock off; resets zero.
// - in sleep, modules with sleep gate bit one are gated; resets to 0x80ff.
// - in deep sleep, modules with deep-sleep gate bit one are gated; resets to 0x80ff.
// - one-hot write to module reset field pulses that peripheral reset; self-clears.
`ifndef CRG_CFG_SVH
`define CRG_CFG_SVH

//----------------------------------------
// register offsets
//----------------------------------------
`define CRG_SLOW_CLOCK_CONTROL 32'h5000_0000
`define CRG_SYSTEM_CLOCK_CONTROL 32'h5000_0004
`define CRG_RESET_CONTROL 32'h5000_0008
`define CRG_MODULE_CLOCK_STOP 32'h5000_000c
`define CRG_SLEEP_CLOCK_GATE 32'h5000_0010
`define CRG_DEEP_SLEEP_CLOCK_GATE 32'h5000_0014
`define CRG_PERIPHERAL_SOFT_RESET 32'h5000_0018

//----------------------------------------
// field positions
//----------------------------------------
`define CRG_SLOW_DIV_LSB 8
`define CRG_SLOW_STS_BIT 0
`define CRG_DWELL_LSB 26
`define CRG_SOFT_EN_BIT 24
`define CRG_LDO_VSEL_LSB 20
`define CRG_FAST_DIV_LSB 16
`define CRG_UNSELECT_BIT 9
`define CRG_CLK_SEL_BIT 8
`define CRG_FAST_STS_BIT 1
`define CRG_FAST_EN_BIT 0
`define CRG_SOFT_RST_BIT 24
`define CRG_HARD_RST_BIT 16
`define CRG_CLEAR_LSB 8

//----------------------------------------
// reset values, divider maximum and masks
//----------------------------------------
`define CRG_SLOW_DIV_RST 4'hf
`define CRG_DWELL_RST 3'h4
`define CRG_SOFT_EN_RST 1'h1
`define CRG_LDO_VSEL_RST 2'h1
`define CRG_FAST_DIV_RST 3'h0
`define CRG_FAST_DIV_MAX 3'h7
`define CRG_CAUSE_MASK 7'h6b
`define CRG_GATE_MASK 16'h80ff
`define CRG_GATE_RST 16'h80ff
`define CRG_STOP_MASK 8'hff

`endif

// ==== design/crg_pkg.sv ====
// crg_pkg.sv: types of the clock/reset control block
`default_nettype none
package crg_pkg;
   typedef enum logic [1:0] {CRG_SS_IDLE, CRG_SS_STEP} crg_ss_t;
   typedef struct packed {
      logic [1:0] rst_sync;
      logic [1:0] por_seen;
      logic [3:0] slow_div;
      logic [3:0] slow_cnt;
      logic slow_tick;
      logic [2:0] dwell;
      logic soft_en;
      logic [1:0] ldo_vsel;
      logic [2:0] fast_div;
      logic unselect;
      logic clk_sel;
      logic fast_en;
      logic [6:0] cause;
      logic [7:0] stop;
      logic [15:0] sleep_gate;
      logic [15:0] deep_gate;
      crg_ss_t ss_state;
      logic [2:0] cur_div;
      logic [8:0] dwell_cnt;
      logic [2:0] fast_cnt;
      logic fast_tick;
      logic soft_rst;
      logic hard_rst;
      logic [7:0] mod_rst;
      logic [15:0] gate_on;
      logic [31:0] rdata;
      logic [2:0] sleep_s;
      logic [2:0] deep_s;
      logic [4:0] ev_s1;
      logic [4:0] ev_s2;
      logic [4:0] ev_s3;
   } crg_state_t;
endpackage
`default_nettype wire

// ==== design/crg_top.sv ====
// crg_top.sv: clock select, soft start, reset requests, cause flags and module gating
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "crg_cfg.svh"
module crg_top (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic [31:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [31:0] RDATA,
   input wire logic CPU_SLEEP,
   input wire logic CPU_DEEP_SLEEP,
   input wire logic LOW_POWER_ENTRY,
   input wire logic OVER_VOLTAGE_EVT,
   input wire logic UNDER_VOLTAGE_EVT,
   input wire logic WATCHDOG_EVT,
   input wire logic OVER_TEMP_EVT,
   output logic SLOW_CLOCK_TICK,
   output logic FAST_CLOCK_TICK,
   output logic SYSTEM_CLOCK_SELECT,
   output logic [2:0] FAST_DIVIDE_NOW,
   output logic FAST_OSC_ON,
   output logic [1:0] FAST_OSC_LDO_SEL,
   output logic [15:0] MODULE_CLOCK_ON,
   output logic CHIP_SOFT_RESET,
   output logic CHIP_HARD_RESET,
   output logic [7:0] MODULE_SOFT_RESET
);
   import crg_pkg::*;

   crg_state_t s_reg;
   crg_state_t s_next;
   logic rst_n_int;
   logic [8:0] dwell_len;
   logic wr_sys;
   logic wr_rst;
   logic [4:0] ev_rise;

   assign rst_n_int = s_reg.rst_sync[1];
   // dwell length minus one: 2^(code+1) cycles per step
   assign dwell_len = 9'((10'h2 << s_reg.dwell) - 10'h1);
   assign wr_sys = WR && (ADDR == `CRG_SYSTEM_CLOCK_CONTROL);
   assign wr_rst = WR && (ADDR == `CRG_RESET_CONTROL);
   // rising edges after the two-flop sync: temp, wdt, uv, ov, low-power entry
   assign ev_rise = s_reg.ev_s2 & ~s_reg.ev_s3;

   //----------------------------------------
   // next-state logic
   //----------------------------------------
   always_comb begin
      s_next = s_reg;
      s_next.rst_sync = {s_reg.rst_sync[0], 1'b1};
      s_next.sleep_s = {s_reg.sleep_s[1:0], CPU_SLEEP};
      s_next.deep_s = {s_reg.deep_s[1:0], CPU_DEEP_SLEEP};
      s_next.ev_s1 = {OVER_TEMP_EVT, WATCHDOG_EVT, UNDER_VOLTAGE_EVT, OVER_VOLTAGE_EVT, LOW_POWER_ENTRY};
      s_next.ev_s2 = s_reg.ev_s1;
      s_next.ev_s3 = s_reg.ev_s2;
      s_next.soft_rst = 1'b0;
      s_next.hard_rst = 1'b0;
      s_next.mod_rst = 8'h00;
      s_next.rdata = 32'h0;

      // power-on seen: set cause, clock select and oscillator enable once
      s_next.por_seen = {s_reg.por_seen[0], 1'b1};
      if (!s_reg.por_seen[1] && s_reg.por_seen[0]) begin
         s_next.cause[0] = 1'b1;
         s_next.clk_sel = 1'b1;
         s_next.fast_en = 1'b1;
      end

      // slow clock divider tick
      s_next.slow_tick = 1'b0;
      if (s_reg.slow_cnt >= s_reg.slow_div) begin
         s_next.slow_cnt = 4'h0;
         s_next.slow_tick = 1'b1;
      end else begin
         s_next.slow_cnt = s_reg.slow_cnt + 4'h1;
      end

      // fast clock divider tick
      s_next.fast_tick = 1'b0;
      if (s_reg.fast_cnt >= s_reg.cur_div) begin
         s_next.fast_cnt = 3'h0;
         s_next.fast_tick = 1'b1;
      end else begin
         s_next.fast_cnt = s_reg.fast_cnt + 3'h1;
      end

      // soft starter
      case (s_reg.ss_state)
         CRG_SS_IDLE: begin
            s_next.cur_div = s_reg.fast_div;
         end
         CRG_SS_STEP: begin
            if (s_reg.cur_div <= s_reg.fast_div) begin
               s_next.cur_div = s_reg.fast_div;
               s_next.ss_state = CRG_SS_IDLE;
            end else if (s_reg.dwell_cnt >= dwell_len) begin
               s_next.dwell_cnt = 9'h0;
               s_next.cur_div = s_reg.cur_div - 3'h1;
            end else begin
               s_next.dwell_cnt = s_reg.dwell_cnt + 9'h1;
            end
         end
         default: s_next.ss_state = CRG_SS_IDLE;
      endcase

      // low-power entry clears the oscillator enable
      if (ev_rise[0]) begin
         s_next.fast_en = 1'b0;
      end

      // fault events set cause flags; set wins over clear below
      if (wr_rst) begin
         s_next.cause = s_reg.cause & ~(WDATA[`CRG_CLEAR_LSB +: 7] & `CRG_CAUSE_MASK);
      end
      s_next.cause = s_next.cause | {ev_rise[4], ev_rise[3], 1'b0, ev_rise[2], 1'b0, ev_rise[1], 1'b0};

      // register writes
      if (WR) begin
         if (ADDR == `CRG_SLOW_CLOCK_CONTROL) begin
            s_next.slow_div = WDATA[`CRG_SLOW_DIV_LSB +: 4];
         end else if (wr_sys) begin
            s_next.dwell = WDATA[`CRG_DWELL_LSB +: 3];
            s_next.soft_en = WDATA[`CRG_SOFT_EN_BIT];
            s_next.ldo_vsel = WDATA[`CRG_LDO_VSEL_LSB +: 2];
            s_next.fast_div = WDATA[`CRG_FAST_DIV_LSB +: 3];
            s_next.unselect = WDATA[`CRG_UNSELECT_BIT];
            s_next.clk_sel = WDATA[`CRG_CLK_SEL_BIT];
            s_next.fast_en = WDATA[`CRG_FAST_EN_BIT] & ~ev_rise[0];
            if (!s_reg.clk_sel && WDATA[`CRG_CLK_SEL_BIT] && s_reg.soft_en) begin
               s_next.ss_state = CRG_SS_STEP;
               s_next.cur_div = `CRG_FAST_DIV_MAX;
               s_next.dwell_cnt = 9'h0;
            end else if (!WDATA[`CRG_CLK_SEL_BIT]) begin
               s_next.ss_state = CRG_SS_IDLE;
            end
         end else if (wr_rst) begin
            s_next.soft_rst = WDATA[`CRG_SOFT_RST_BIT];
            s_next.hard_rst = WDATA[`CRG_HARD_RST_BIT];
         end else if (ADDR == `CRG_MODULE_CLOCK_STOP) begin
            s_next.stop = WDATA[7:0] & `CRG_STOP_MASK;
         end else if (ADDR == `CRG_SLEEP_CLOCK_GATE) begin
            s_next.sleep_gate = WDATA[15:0] & `CRG_GATE_MASK;
         end else if (ADDR == `CRG_DEEP_SLEEP_CLOCK_GATE) begin
            s_next.deep_gate = WDATA[15:0] & `CRG_GATE_MASK;
         end else if (ADDR == `CRG_PERIPHERAL_SOFT_RESET) begin
            s_next.mod_rst = WDATA[7:0];
         end
      end

      // module clock enables: stop forces off, sleep gates apply by mode
      s_next.gate_on = 16'hffff;
      s_next.gate_on[7:0] = ~s_reg.stop;
      if (s_reg.sleep_s[2]) begin
         s_next.gate_on = s_next.gate_on & ~s_reg.sleep_gate;
      end
      if (s_reg.deep_s[2]) begin
         s_next.gate_on = s_next.gate_on & ~s_reg.deep_gate;
      end
      s_next.gate_on = s_next.gate_on & `CRG_GATE_MASK;

      // read data, stands one cycle after the strobe; unmapped reads zero
      if (RD) begin
         if (ADDR == `CRG_SLOW_CLOCK_CONTROL) begin
            s_next.rdata[`CRG_SLOW_DIV_LSB +: 4] = s_reg.slow_div;
            s_next.rdata[`CRG_SLOW_STS_BIT] = ~s_reg.clk_sel;
         end else if (ADDR == `CRG_SYSTEM_CLOCK_CONTROL) begin
            s_next.rdata[`CRG_DWELL_LSB +: 3] = s_reg.dwell;
            s_next.rdata[`CRG_SOFT_EN_BIT] = s_reg.soft_en;
            s_next.rdata[`CRG_LDO_VSEL_LSB +: 2] = s_reg.ldo_vsel;
            s_next.rdata[`CRG_FAST_DIV_LSB +: 3] = s_reg.fast_div;
            s_next.rdata[`CRG_UNSELECT_BIT] = s_reg.unselect;
            s_next.rdata[`CRG_CLK_SEL_BIT] = s_reg.clk_sel;
            s_next.rdata[`CRG_FAST_STS_BIT] = s_reg.fast_en | s_reg.clk_sel;
            s_next.rdata[`CRG_FAST_EN_BIT] = s_reg.fast_en;
         end else if (ADDR == `CRG_RESET_CONTROL) begin
            s_next.rdata[6:0] = s_reg.cause;
         end else if (ADDR == `CRG_MODULE_CLOCK_STOP) begin
            s_next.rdata[7:0] = s_reg.stop;
         end else if (ADDR == `CRG_SLEEP_CLOCK_GATE) begin
            s_next.rdata[15:0] = s_reg.sleep_gate;
         end else if (ADDR == `CRG_DEEP_SLEEP_CLOCK_GATE) begin
            s_next.rdata[15:0] = s_reg.deep_gate;
         end else if (ADDR == `CRG_PERIPHERAL_SOFT_RESET) begin
            s_next.rdata[7:0] = 8'h00;
         end
      end
   end

   //----------------------------------------
   // state register
   //----------------------------------------
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         s_reg <= '0;
         s_reg.slow_div <= `CRG_SLOW_DIV_RST;
         s_reg.dwell <= `CRG_DWELL_RST;
         s_reg.soft_en <= `CRG_SOFT_EN_RST;
         s_reg.ldo_vsel <= `CRG_LDO_VSEL_RST;
         s_reg.fast_div <= `CRG_FAST_DIV_RST;
         s_reg.sleep_gate <= `CRG_GATE_RST;
         s_reg.deep_gate <= `CRG_GATE_RST;
         s_reg.gate_on <= `CRG_GATE_MASK;
         s_reg.ss_state <= CRG_SS_IDLE;
      end else if (!rst_n_int) begin
         s_reg.rst_sync <= s_next.rst_sync;
      end else begin
         s_reg <= s_next;
      end
   end

   //----------------------------------------
   // outputs, all from flip-flops
   //----------------------------------------
   assign RDATA = s_reg.rdata;
   assign SLOW_CLOCK_TICK = s_reg.slow_tick;
   assign FAST_CLOCK_TICK = s_reg.fast_tick;
   assign SYSTEM_CLOCK_SELECT = s_reg.clk_sel;
   assign FAST_DIVIDE_NOW = s_reg.cur_div;
   assign FAST_OSC_ON = s_reg.fast_en;
   assign FAST_OSC_LDO_SEL = s_reg.ldo_vsel;
   assign MODULE_CLOCK_ON = s_reg.gate_on;
   assign CHIP_SOFT_RESET = s_reg.soft_rst;
   assign CHIP_HARD_RESET = s_reg.hard_rst;
   assign MODULE_SOFT_RESET = s_reg.mod_rst;
endmodule
`default_nettype wire

// ==== tb/crg_top_checker.sv ====
// crg_top_checker.sv: port assertions for the clock and reset control block
`timescale 1ns/1ps
`default_nettype none
module crg_top_checker (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic [31:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   input wire logic [31:0] RDATA,
   input wire logic SYSTEM_CLOCK_SELECT,
   input wire logic [2:0] FAST_DIVIDE_NOW,
   input wire logic [15:0] MODULE_CLOCK_ON,
   input wire logic CHIP_SOFT_RESET,
   input wire logic CHIP_HARD_RESET,
   input wire logic [7:0] MODULE_SOFT_RESET
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_N);
   //----------------------------------------
   // reset pulses
   //----------------------------------------
   soft_pulse_a: assert property (CHIP_SOFT_RESET |=> !CHIP_SOFT_RESET)
      else $error("soft reset pulse too long");
   hard_pulse_a: assert property (CHIP_HARD_RESET |=> !CHIP_HARD_RESET)
      else $error("hard reset pulse too long");
   modrst_pulse_a: assert property (MODULE_SOFT_RESET != 8'h00 |=> MODULE_SOFT_RESET == 8'h00)
      else $error("module reset pulse too long");
   soft_cause_a: assert property (WR && ADDR == 32'h5000_0008 && WDATA[24] |-> ##[1:2] CHIP_SOFT_RESET)
      else $error("soft reset request lost");
   modrst_cause_a: assert property (WR && ADDR == 32'h5000_0018 && WDATA[7:0] == 8'h80
      |-> ##[1:2] MODULE_SOFT_RESET == 8'h80) else $error("module reset request lost");
   //----------------------------------------
   // gating and read data
   //----------------------------------------
   gate_gap_a: assert property (MODULE_CLOCK_ON[14:8] == 7'h00)
      else $error("unused clock enables set");
   clear_zero_a: assert property (RD && ADDR == 32'h5000_0008 |=> RDATA[31:7] == 25'h0)
      else $error("clear or request bits read high");
   slow_sts_a: assert property (RD && ADDR == 32'h5000_0000 ##1 $stable(SYSTEM_CLOCK_SELECT)
      |-> RDATA[0] == !SYSTEM_CLOCK_SELECT) else $error("slow status wrong");
   fast_sts_a: assert property (RD && ADDR == 32'h5000_0004 |=> RDATA[1] == (RDATA[0] | RDATA[8]))
      else $error("fast status wrong");
   soft_c: cover property (CHIP_SOFT_RESET);
   start_c: cover property (SYSTEM_CLOCK_SELECT && FAST_DIVIDE_NOW == 3'h7);
   modrst_c: cover property (MODULE_SOFT_RESET == 8'h80);
endmodule
bind crg_top crg_top_checker chk (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
   .RDATA(RDATA), .SYSTEM_CLOCK_SELECT(SYSTEM_CLOCK_SELECT), .FAST_DIVIDE_NOW(FAST_DIVIDE_NOW),
   .MODULE_CLOCK_ON(MODULE_CLOCK_ON), .CHIP_SOFT_RESET(CHIP_SOFT_RESET), .CHIP_HARD_RESET(CHIP_HARD_RESET),
   .MODULE_SOFT_RESET(MODULE_SOFT_RESET));
`default_nettype wire

// ==== tb/crg_top_bench.sv ====
// crg_top_bench.sv: register-level tests of the clock and reset control block
`timescale 1ns/1ps
`default_nettype none
module crg_top_bench;
   logic clk, rst_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0, slp = 1'b0, dslp = 1'b0, lpe = 1'b0, rec = 1'b0;
   logic [31:0] addr = 32'h0, wdata = 32'h0, d;
   logic [3:0] evt = 4'h0;
   logic [7:0] mod_seen = 8'h0;
   wire [31:0] rdata;
   wire [15:0] mod_on;
   wire [7:0] mod_rst;
   wire [2:0] div_now;
   wire [1:0] ldo;
   wire slow_tick, fast_tick, sel, osc_on, soft_rst, hard_rst;
   int err_total = 0, checks = 0, n_slow = 0, n_fast = 0, n_soft = 0, n_hard = 0, k;
   int hist[8];
   crg_top uut (.CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr_en), .RD(rd_en), .RDATA(rdata),
      .CPU_SLEEP(slp), .CPU_DEEP_SLEEP(dslp), .LOW_POWER_ENTRY(lpe), .OVER_VOLTAGE_EVT(evt[0]),
      .UNDER_VOLTAGE_EVT(evt[1]), .WATCHDOG_EVT(evt[2]), .OVER_TEMP_EVT(evt[3]), .SLOW_CLOCK_TICK(slow_tick),
      .FAST_CLOCK_TICK(fast_tick), .SYSTEM_CLOCK_SELECT(sel), .FAST_DIVIDE_NOW(div_now), .FAST_OSC_ON(osc_on),
      .FAST_OSC_LDO_SEL(ldo), .MODULE_CLOCK_ON(mod_on), .CHIP_SOFT_RESET(soft_rst),
      .CHIP_HARD_RESET(hard_rst), .MODULE_SOFT_RESET(mod_rst));
   //----------------------------------------
   // clock, output monitors, watchdog
   //----------------------------------------
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      n_slow += slow_tick;
      n_fast += fast_tick;
      n_soft += soft_rst;
      n_hard += hard_rst;
      if (mod_rst != 8'h0) mod_seen <= mod_rst;
      if (rec) hist[div_now]++;
   end
   initial begin
      repeat (10000) @(posedge clk);
      err_total++;
      results();
   end
   //----------------------------------------
   // bus tasks and compares
   //----------------------------------------
   task wr(input logic [31:0] a, input logic [31:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask
   task rd(input logic [31:0] a, output logic [31:0] v);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1 v = rdata;
   endtask
   task cmp(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         err_total++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task rcmp(input string n, input logic [31:0] a, input logic [31:0] e);
      rd(a, d);
      cmp(n, e, d);
   endtask
   task idle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task results;
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   //----------------------------------------
   // test sequence
   //----------------------------------------
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      idle(8);
      rcmp("slow ctl", 32'h5000_0000, 32'h0000_0f00);
      rcmp("sys ctl", 32'h5000_0004, 32'h1110_0103);
      cmp("select pin", 32'h1, {31'h0, sel});
      cmp("ldo pin", 32'h1, {30'h0, ldo});
      rcmp("causes", 32'h5000_0008, 32'h0000_0001);
      rcmp("stop", 32'h5000_000c, 32'h0);
      rcmp("sleep gate", 32'h5000_0010, 32'h80ff);
      rcmp("deep gate", 32'h5000_0014, 32'h80ff);
      rcmp("unmapped", 32'h5000_001c, 32'h0);
      $display("reset values done");
      wr(32'h5000_000c, 32'hffff_ffa5);
      rcmp("stop", 32'h5000_000c, 32'ha5);
      idle(2);
      cmp("clock on", 32'h805a, {16'h0, mod_on});
      wr(32'h5000_000c, 32'h0);
      wr(32'h5000_0010, 32'h8001);
      slp <= 1'b1;
      idle(6);
      cmp("sleep clocks", 32'h00fe, {16'h0, mod_on});
      slp <= 1'b0;
      dslp <= 1'b1;
      idle(6);
      cmp("deep clocks", 32'h0, {16'h0, mod_on});
      dslp <= 1'b0;
      idle(6);
      cmp("awake clocks", 32'h80ff, {16'h0, mod_on});
      $display("gating done");
      evt <= 4'hf;
      idle(3);
      evt <= 4'h0;
      idle(6);
      rcmp("causes", 32'h5000_0008, 32'h6b);
      wr(32'h5000_0008, 32'h2100);
      idle(4);
      rcmp("causes", 32'h5000_0008, 32'h4a);
      wr(32'h5000_0008, 32'h4a00);
      rcmp("causes", 32'h5000_0008, 32'h0);
      evt <= 4'h4;
      idle(1);
      wr(32'h5000_0008, 32'h2000);
      evt <= 4'h0;
      rcmp("set wins", 32'h5000_0008, 32'h20);
      wr(32'h5000_0008, 32'h2000);
      wr(32'h5000_0008, 32'h0100_0000);
      idle(3);
      cmp("soft pulses", 32'h1, n_soft);
      wr(32'h5000_0008, 32'h0001_0000);
      idle(3);
      cmp("hard pulses", 32'h1, n_hard);
      rcmp("req bits", 32'h5000_0008, 32'h0);
      for (int i = 0; i < 8; i++) begin
         wr(32'h5000_0018, 32'h1 << i);
         idle(3);
         cmp("module reset", 32'h1 << i, {24'h0, mod_seen});
      end
      rcmp("module reset rd", 32'h5000_0018, 32'h0);
      $display("resets done");
      wr(32'h5000_0000, 32'h0000_0300);
      idle(2);
      k = n_slow;
      idle(40);
      cmp("slow ticks", 32'ha, n_slow - k);
      wr(32'h5000_0004, 32'h0512_0001);
      idle(2);
      rcmp("slow ctl", 32'h5000_0000, 32'h0000_0301);
      rcmp("sys ctl", 32'h5000_0004, 32'h0512_0003);
      cmp("select pin", 32'h0, {31'h0, sel});
      idle(3000);
      hist = '{default: 0};
      rec = 1'b1;
      wr(32'h5000_0004, 32'h0512_0101);
      idle(40);
      rec = 1'b0;
      for (int j = 3; j < 8; j++) cmp("dwell steps", 32'h4, hist[j]);
      cmp("final divide", 32'h2, {29'h0, div_now});
      cmp("select pin", 32'h1, {31'h0, sel});
      k = n_fast;
      idle(30);
      cmp("fast ticks", 32'ha, n_fast - k);
      $display("dividers done");
      wr(32'h5000_0004, 32'h0510_0000);
      idle(2);
      rcmp("osc off", 32'h5000_0004, 32'h0510_0000);
      wr(32'h5000_0004, 32'h0510_0001);
      lpe <= 1'b1;
      idle(6);
      lpe <= 1'b0;
      rcmp("osc entry", 32'h5000_0004, 32'h0510_0000);
      cmp("osc pin", 32'h0, {31'h0, osc_on});
      $display("oscillator done");
      results();
   end
endmodule
`default_nettype wire
